//--- design/option_trim_loader.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module option_trim_loader (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [15:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // flash events
  input  wire logic         pageZeroErase,
  input  wire logic         debugMassErase,
  // core program-space fetch
  input  wire logic [15:0]  progAddr,
  output logic              progInInfoWin,
  // configuration holders
  output otl_pkg::otl_cfg_t cfg,
  output logic              cfgValid,
  output logic              coreRelease,
  // watchdog and power qualifiers
  input  wire logic         watchdogArmInstr,
  input  wire logic         stopRecovery,
  input  wire logic         stopMode,
  input  wire logic         powerCtlBorOff,
  output logic              watchdogRunning,
  output logic              brownoutEnable,
  output logic              userFlashWriteOk,
  output logic              debugMassEraseOk
);

  ////////////////////////////////////////////////////////////////////////////
  // storage: option bytes (page zero) and information page

  // flash cells power up erased; no reset touches them
  logic [7:0] opt0_q = otl_pkg::ERASED_BYTE;
  logic [7:0] opt0_d;
  logic [7:0] opt1_q = otl_pkg::ERASED_BYTE;
  logic [7:0] opt1_d;
  logic [7:0] infoMem [otl_pkg::INFO_DEPTH];
  logic [7:0] trimWork [otl_pkg::TRIM_COUNT];

  function automatic logic [11:0] regIndex(input logic [15:0] a);
    regIndex = a[13:2];
  endfunction

  function automatic logic [8:0] trimToInfo(input logic [4:0] i);
    trimToInfo = otl_pkg::TRIM_BASE + {4'h0, i};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic        access;
  logic        wrEn;
  logic        rdEn;
  logic [11:0] idx;
  logic        mapped;

  assign idx     = regIndex(paddr);
  assign access  = psel & penable;
  assign mapped  = (idx == otl_pkg::OPT0_IDX) | (idx == otl_pkg::OPT1_IDX) |
                   (idx == otl_pkg::TRIM_IDX_IDX) | (idx == otl_pkg::TRIM_VAL_IDX) |
                   (idx == otl_pkg::PAGE_SEL_IDX) | (idx == otl_pkg::INFO_ADDR_IDX) |
                   (idx == otl_pkg::INFO_DATA_IDX) | (idx == otl_pkg::STATUS_IDX);
  assign wrEn    = access & pwrite & pstrb[0] & mapped & (paddr[1:0] == 2'b00);
  assign rdEn    = access & ~pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = access & (~mapped | (paddr[1:0] != 2'b00));

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer

  otl_pkg::otl_state_t state_q, state_d;
  logic [4:0]          ldCnt_q, ldCnt_d;
  otl_pkg::otl_cfg_t   cfg_q, cfg_d;

  always_comb begin
    state_d = state_q;
    ldCnt_d = ldCnt_q;
    cfg_d   = cfg_q;
    unique case (state_q)
      otl_pkg::OTL_LOAD_OPT: begin
        cfg_d.wdtIrqNotReset     = ~opt0_q[otl_pkg::WDT_ACTION_BIT];
        cfg_d.wdtAlwaysOn        = ~opt0_q[otl_pkg::WDT_AON_BIT];
        cfg_d.borMayStopOff      = ~opt0_q[otl_pkg::BOR_AON_BIT];
        cfg_d.codeReadable       = opt0_q[otl_pkg::READ_PROT_BIT];
        cfg_d.userEraseAllowed   = opt0_q[otl_pkg::WRITE_PROT_BIT];
        cfg_d.crystalRunsAtReset = ~opt1_q[otl_pkg::XTAL_OFF_BIT];
        ldCnt_d = 5'h00;
        state_d = otl_pkg::OTL_LOAD_TRIM;
      end
      otl_pkg::OTL_LOAD_TRIM: begin
        ldCnt_d = ldCnt_q + 5'h01;
        if (ldCnt_q == 5'h1F) begin
          state_d = otl_pkg::OTL_READY;
        end
      end
      otl_pkg::OTL_READY: begin
      end
      default: begin
        state_d = otl_pkg::OTL_LOAD_OPT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= otl_pkg::OTL_LOAD_OPT;
      ldCnt_q <= 5'h00;
      cfg_q   <= '0;
    end else begin
      state_q <= state_d;
      ldCnt_q <= ldCnt_d;
      cfg_q   <= cfg_d;
    end
  end

  assign cfgValid    = (state_q != otl_pkg::OTL_LOAD_OPT);
  assign coreRelease = (state_q == otl_pkg::OTL_READY);
  assign cfg         = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] trimIdx_q, trimIdx_d;
  logic [7:0] pageSel_q, pageSel_d;
  logic [8:0] infoPtr_q, infoPtr_d;
  logic       hold;

  // page zero erase wins over option writes
  always_comb begin
    opt0_d    = opt0_q;
    opt1_d    = opt1_q;
    trimIdx_d = trimIdx_q;
    pageSel_d = pageSel_q;
    infoPtr_d = infoPtr_q;
    hold      = ~cfg_q.userEraseAllowed;
    if (wrEn && idx == otl_pkg::OPT0_IDX && !hold) begin
      opt0_d = pwdata[7:0] | otl_pkg::OPT0_RSVD_MASK;
    end
    if (wrEn && idx == otl_pkg::OPT1_IDX && !hold) begin
      opt1_d = pwdata[7:0] | otl_pkg::OPT1_RSVD_MASK;
    end
    if (wrEn && idx == otl_pkg::TRIM_IDX_IDX) begin
      trimIdx_d = pwdata[7:0];
    end
    if (wrEn && idx == otl_pkg::PAGE_SEL_IDX) begin
      pageSel_d = pwdata[7:0];
    end
    if (wrEn && idx == otl_pkg::INFO_ADDR_IDX) begin
      infoPtr_d = pwdata[8:0];
    end
    if ((pageZeroErase && !hold) || debugMassErase) begin
      opt0_d = otl_pkg::ERASED_BYTE;
      opt1_d = otl_pkg::ERASED_BYTE;
    end
  end

  // option bytes held in flash, not cleared by reset
  always_ff @(posedge clk) begin
    opt0_q <= opt0_d;
    opt1_q <= opt1_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimIdx_q <= otl_pkg::TRIM_IDX_RST;
      pageSel_q <= otl_pkg::PAGE_SEL_RST;
      infoPtr_q <= 9'h000;
    end else begin
      trimIdx_q <= trimIdx_d;
      pageSel_q <= pageSel_d;
      infoPtr_q <= infoPtr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trim working copies

  logic [4:0] trimSel;
  logic       trimWr;
  logic       trimInRange;

  // only 00H to 1FH map onto info 20 to 3F
  assign trimInRange = (trimIdx_q[7:5] == 3'b000);
  assign trimSel     = trimIdx_q[4:0];
  assign trimWr      = wrEn & (idx == otl_pkg::TRIM_VAL_IDX) & trimInRange & coreRelease;

  // reload from factory copy after reset; factory byte never written
  always_ff @(posedge clk) begin
    if (state_q == otl_pkg::OTL_LOAD_TRIM) begin
      trimWork[ldCnt_q] <= infoMem[trimToInfo(ldCnt_q)];
    end else if (trimWr) begin
      trimWork[trimSel] <= pwdata[7:0];
    end
  end

  // info page has no write or erase path
  initial begin
    for (int i = 0; i < otl_pkg::INFO_DEPTH; i++) begin
      infoMem[i] = otl_pkg::ERASED_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [7:0]  rdByte;
  logic [31:0] prdata_q, prdata_d;
  logic        infoSel;

  assign infoSel = pageSel_q[otl_pkg::INFO_SEL_BIT];

  always_comb begin
    rdByte = 8'h00;
    unique case (idx)
      otl_pkg::OPT0_IDX:      rdByte = opt0_q | otl_pkg::OPT0_RSVD_MASK;
      otl_pkg::OPT1_IDX:      rdByte = opt1_q | otl_pkg::OPT1_RSVD_MASK;
      otl_pkg::TRIM_IDX_IDX:  rdByte = trimIdx_q;
      otl_pkg::TRIM_VAL_IDX:  rdByte = trimInRange ? trimWork[trimSel] : 8'h00;
      otl_pkg::PAGE_SEL_IDX:  rdByte = pageSel_q;
      otl_pkg::INFO_ADDR_IDX: rdByte = infoPtr_q[7:0];
      otl_pkg::INFO_DATA_IDX: rdByte = infoSel ? infoMem[infoPtr_q] : 8'h00;
      otl_pkg::STATUS_IDX:    rdByte = {5'h00, infoSel, cfgValid, coreRelease};
      default:                rdByte = 8'h00;
    endcase
    prdata_d = rdEn ? {24'h000000, rdByte} : prdata_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // read data is combinational within the access cycle
  assign prdata = rdEn ? {24'h000000, rdByte} : prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // option effects

  logic wdRun_q, wdRun_d;

  assign progInInfoWin = infoSel & (progAddr >= otl_pkg::INFO_WIN_LO) &
                         (progAddr <= otl_pkg::INFO_WIN_HI);

  always_comb begin
    wdRun_d = wdRun_q;
    if (stopRecovery && !cfg_q.wdtAlwaysOn) begin
      wdRun_d = 1'b0;
    end
    if (watchdogArmInstr && coreRelease) begin
      wdRun_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdRun_q <= 1'b0;
    end else begin
      wdRun_q <= wdRun_d;
    end
  end

  assign watchdogRunning  = cfgValid & (cfg_q.wdtAlwaysOn | wdRun_q);
  // brownout drop only in stop with power bit
  assign brownoutEnable   = ~(cfg_q.borMayStopOff & stopMode & powerCtlBorOff);
  assign userFlashWriteOk = cfgValid & cfg_q.userEraseAllowed;
  assign debugMassEraseOk = 1'b1;

endmodule

`default_nettype wire

//--- shared/otl_pkg.sv
package otl_pkg;

  // register byte offsets: printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it
  localparam logic [11:0] OPT0_IDX      = 12'h000;
  localparam logic [11:0] OPT1_IDX      = 12'h001;
  localparam logic [11:0] TRIM_IDX_IDX  = 12'hFF6;
  localparam logic [11:0] TRIM_VAL_IDX  = 12'hFF7;
  localparam logic [11:0] PAGE_SEL_IDX  = 12'hFF9;
  localparam logic [11:0] INFO_ADDR_IDX = 12'hFE0;
  localparam logic [11:0] INFO_DATA_IDX = 12'hFE1;
  localparam logic [11:0] STATUS_IDX    = 12'hFE2;

  // option byte 0 field positions
  localparam int WDT_ACTION_BIT = 7;
  localparam int WDT_AON_BIT    = 6;
  localparam int BOR_AON_BIT    = 3;
  localparam int READ_PROT_BIT  = 2;
  localparam int WRITE_PROT_BIT = 0;
  // option byte 1 field position
  localparam int XTAL_OFF_BIT   = 4;

  // reserved bits forced to one on read
  localparam logic [7:0] OPT0_RSVD_MASK = 8'h32;
  localparam logic [7:0] OPT1_RSVD_MASK = 8'hEF;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;

  // page select field
  localparam int INFO_SEL_BIT = 7;

  // information page layout
  localparam int          INFO_DEPTH    = 512;
  localparam int          TRIM_COUNT    = 32;
  localparam logic [8:0]  TRIM_BASE     = 9'h020;
  localparam logic [8:0]  SERIAL_BASE   = 9'h01C;
  localparam logic [8:0]  LOT_BASE      = 9'h040;
  localparam logic [15:0] INFO_WIN_LO   = 16'hFE00;
  localparam logic [15:0] INFO_WIN_HI   = 16'hFFFF;

  localparam logic [7:0] TRIM_IDX_RST = 8'h00;
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;

  typedef enum logic [1:0] {
    OTL_LOAD_OPT  = 2'b00,
    OTL_LOAD_TRIM = 2'b01,
    OTL_READY     = 2'b11
  } otl_state_t;

  typedef struct packed {
    logic wdtIrqNotReset;
    logic wdtAlwaysOn;
    logic borMayStopOff;
    logic codeReadable;
    logic userEraseAllowed;
    logic crystalRunsAtReset;
  } otl_cfg_t;

endpackage

//--- testbench/otl_flash_model.sv
`timescale 1ns/100ps
`default_nettype none

module otl_flash_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // erase request from the bench: 1 page zero, 2 debugger mass erase
  input  wire logic [1:0] eraseCmd,
  // erase events toward the loader
  output logic            pageZeroErase,
  output logic            debugMassErase
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pageZeroErase  <= 1'b0;
      debugMassErase <= 1'b0;
    end else begin
      pageZeroErase  <= (eraseCmd == 2'h1);
      debugMassErase <= (eraseCmd == 2'h2);
    end
  end
endmodule

`default_nettype wire

//--- testbench/otl_properties.sv
`timescale 1ns/100ps
`default_nettype none

module otl_properties (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // apb
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic              pready,
  input  wire logic [31:0]       prdata,
  input  wire logic              pslverr,
  // program space and configuration
  input  wire logic [15:0]       progAddr,
  input  wire logic              progInInfoWin,
  input  wire otl_pkg::otl_cfg_t cfg,
  input  wire logic              cfgValid,
  input  wire logic              coreRelease,
  input  wire logic              stopMode,
  input  wire logic              powerCtlBorOff,
  input  wire logic              watchdogRunning,
  input  wire logic              brownoutEnable,
  input  wire logic              userFlashWriteOk,
  input  wire logic              debugMassEraseOk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rdAcc = psel && penable && !pwrite;
  ////////////////////////////////////////////////////////////////////////
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_upper; rdAcc |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rsvd; rdAcc && paddr == 16'h0000 |-> &(prdata[7:0] | ~otl_pkg::OPT0_RSVD_MASK); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read low");
  property p_hold; cfgValid && $past(cfgValid) |-> $stable(cfg); endproperty
  a_hold: assert property (p_hold) else $error("config changed without reset");
  property p_boot; $rose(cfgValid) |-> !coreRelease ##32 $rose(coreRelease); endproperty
  a_boot: assert property (p_boot) else $error("core release timing");
  property p_win; progInInfoWin |-> progAddr >= otl_pkg::INFO_WIN_LO; endproperty
  a_win: assert property (p_win) else $error("info window below base");
  property p_wdt; coreRelease && cfg.wdtAlwaysOn |-> watchdogRunning; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not running");
  property p_bor; cfgValid |-> brownoutEnable == !(cfg.borMayStopOff && stopMode && powerCtlBorOff); endproperty
  a_bor: assert property (p_bor) else $error("brownout enable wrong");
  property p_wp; cfgValid |-> userFlashWriteOk == cfg.userEraseAllowed && debugMassEraseOk; endproperty
  a_wp: assert property (p_wp) else $error("flash write permission wrong");
  c_boot: cover property ($rose(coreRelease));
  c_err: cover property (pslverr);
  c_win: cover property (progInInfoWin);
endmodule

bind option_trim_loader otl_properties u_props (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .progAddr, .progInInfoWin, .cfg, .cfgValid, .coreRelease, .stopMode, .powerCtlBorOff,
  .watchdogRunning, .brownoutEnable, .userFlashWriteOk, .debugMassEraseOk);

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end

module testbench;
  localparam logic [11:0] O0 = otl_pkg::OPT0_IDX, O1 = otl_pkg::OPT1_IDX;
  localparam logic [11:0] TI = otl_pkg::TRIM_IDX_IDX, TV = otl_pkg::TRIM_VAL_IDX;
  localparam logic [11:0] PS = otl_pkg::PAGE_SEL_IDX, IA = otl_pkg::INFO_ADDR_IDX, ID = otl_pkg::INFO_DATA_IDX;
  logic              clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic              pageZeroErase, debugMassErase, progInInfoWin, cfgValid, coreRelease;
  logic              wdArm, stopMode, pwrOff, watchdogRunning, brownoutEnable, userFlashWriteOk, massOk;
  logic              stopRec;
  logic [1:0]        eraseCmd;
  logic [15:0]       paddr, progAddr;
  logic [31:0]       pwdata, prdata, rd;
  otl_pkg::otl_cfg_t cfg;
  int                errors, cmp_count;

  option_trim_loader uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pageZeroErase(pageZeroErase), .debugMassErase(debugMassErase), .progAddr(progAddr),
    .progInInfoWin(progInInfoWin), .cfg(cfg), .cfgValid(cfgValid), .coreRelease(coreRelease),
    .watchdogArmInstr(wdArm), .stopRecovery(stopRec), .stopMode(stopMode), .powerCtlBorOff(pwrOff),
    .watchdogRunning(watchdogRunning), .brownoutEnable(brownoutEnable),
    .userFlashWriteOk(userFlashWriteOk), .debugMassEraseOk(massOk));
  otl_flash_model u_flash (.clk(clk), .resetn(resetn), .eraseCmd(eraseCmd),
    .pageZeroErase(pageZeroErase), .debugMassErase(debugMassErase));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      test_done;
    end
  endtask

  task automatic wr(input logic [11:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask

  task automatic rd8(input logic [11:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask

  task automatic boot;
    int n;
    n = 0;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    while (coreRelease !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      errors++;
      test_done;
    end
  endtask

  task automatic pulse_erase(input logic [1:0] c);
    @(posedge clk);
    eraseCmd <= c;
    @(posedge clk);
    eraseCmd <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, psel, penable, pwrite, wdArm, stopMode, pwrOff, stopRec} = '0;
    {eraseCmd, paddr, progAddr, pwdata, errors, cmp_count} = '0;
    boot;
    `CHK(cfg, 6'b000110)
    `CHK(massOk, 1'b1)
    rd8(O0, 8'hFF);
    rd8(TI, otl_pkg::TRIM_IDX_RST);
    `CHK(watchdogRunning, 1'b0)
    wdArm <= 1'b1;
    stopMode <= 1'b1;
    pwrOff <= 1'b1;
    @(posedge clk);
    wdArm <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(watchdogRunning, 1'b1)
    `CHK(brownoutEnable, 1'b1)
    // stop-mode recovery halts an instruction-armed watchdog
    stopRec <= 1'b1;
    @(posedge clk);
    stopRec <= 1'b0;
    @(posedge clk);
    `CHK(watchdogRunning, 1'b0)
    $display("test boot done");
    wr(TI, 8'h1F);
    wr(TV, 8'hA5);
    wr(TI, 8'h00);
    wr(TV, 8'h3C);
    wr(TI, 8'h1F);
    rd8(TV, 8'hA5);
    wr(TI, 8'h00);
    rd8(TV, 8'h3C);
    wr(TI, 8'h20);
    rd8(TV, 8'h00);
    wr(PS, 8'h80);
    wr(IA, 8'h3F);
    rd8(ID, 8'hFF);
    wr(PS, 8'h00);
    rd8(ID, 8'h00);
    apb(1'b0, 12'h040, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test trim done");
    wr(O0, 8'h00);
    wr(O1, 8'h00);
    rd8(O0, 8'h32);
    rd8(O1, 8'hEF);
    `CHK(cfg, 6'b000110)
    boot;
    `CHK(cfg, 6'b111001)
    `CHK({watchdogRunning, brownoutEnable, userFlashWriteOk}, 3'b100)
    wr(TI, 8'h1F);
    rd8(TV, 8'hFF);
    $display("test options done");
    pulse_erase(2'h1);
    wr(O0, 8'hFF);
    rd8(O0, 8'h32);
    pulse_erase(2'h2);
    rd8(O0, 8'hFF);
    wr(PS, 8'h80);
    wr(IA, 8'h1C);
    rd8(ID, 8'hFF);
    wr(IA, 8'h40);
    rd8(ID, 8'hFF);
    progAddr <= 16'hFE10;
    @(posedge clk);
    @(posedge clk);
    `CHK(progInInfoWin, 1'b1)
    progAddr <= 16'hFDFF;
    @(posedge clk);
    @(posedge clk);
    `CHK(progInInfoWin, 1'b0)
    $display("test erase done");
    stopMode <= 1'b0;
    boot;
    wr(O0, 8'h7F);
    rd8(O0, 8'h7F);
    pulse_erase(2'h1);
    rd8(O0, 8'hFF);
    $display("test page erase done");
    test_done;
  end
endmodule

`default_nettype wire
